// >>> pad_model.sv
/* Pad model for the pins of port B and port C.
   The pad's own drive wins over the outside driver, which the bench enables on every pin. */
module pad_model #(
  parameter int N = 7
) (
  // Pad controls
  input wire logic i_core_clk,
  input wire logic [N-1:0] i_out,
  input wire logic [N-1:0] i_oe_n,
  input wire logic [N-1:0] i_pull_up,
  // Outside driver
  input wire logic [N-1:0] i_ext_en,
  input wire logic [N-1:0] i_ext,
  // Pin levels
  output logic [N-1:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip = 1'b0;
  // A floating pin without pull-up shows a level that changes every cycle.
  always @(posedge i_core_clk)
    flip <= ~flip;
  always_comb
    for (int k = 0; k < N; k++)
      o_pin[k] = !i_oe_n[k] ? i_out[k] : i_ext_en[k] ? i_ext[k] : i_pull_up[k] ? 1'b1 : flip;
endmodule

// >>> pin_mux_pkg.sv
/*
  Package for the port B/C alternate-function override logic: pin override
  record, per-pin bundles and bit positions of the pin groups.
  Assumes a single system clock domain and no register bus.
*/
package pin_mux_pkg;

  // ---------------------------------------------------------------
  // Pin indices
  // ---------------------------------------------------------------
  localparam int PB0 = 0;
  localparam int PB1 = 1;
  localparam int PB2 = 2;
  localparam int PB3 = 3;
  localparam int PC0 = 0;
  localparam int PC1 = 1;
  localparam int PC2 = 2;
  localparam int N_PB = 4;
  localparam int N_PC = 3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic RST_SYNC = 1'b0;

  // Port register setting of one pin as software left it.
  typedef struct packed {
    logic out_bit;
    logic dir_bit;
  } port_bits_t;

  // Resolved pin controls after overrides.
  typedef struct packed {
    logic pull_up;
    logic drive;
    logic value;
    logic din_en;
  } pin_ctrl_t;

  // Override enables and values of one pin.
  typedef struct packed {
    logic pu_oe;
    logic pu_ov;
    logic dd_oe;
    logic dd_ov;
    logic pv_oe;
    logic pv_ov;
    logic die_oe;
    logic die_ov;
  } override_t;

  // Peripheral-side requests.
  typedef struct packed {
    logic uart0_tx_owns_pin;
    logic uart0_tx_value;
    logic uart1_tx_owns_pin;
    logic uart_tx_pin_value;
    logic uart1_rx_active;
    logic uart1_rx_owns_pin;
    logic uart1_rx_pullup;
    logic serial_if_three_wire_mode;
    logic serial_if_two_wire_mode;
    logic serial_if_start_irq_en;
    logic three_wire_data_out;
    logic t1_cmp_a_en;
    logic t1_cmp_a_out;
    logic t0_cmp_a_en;
    logic t0_cmp_a_out;
    logic usart0_sync_mode;
    logic clock_out_fuse;
    logic ext_irq0;
    logic pinchg_group1_en;
  } periph_req_t;

endpackage

// >>> pmux_assertions.sv
/* Assertions on the pad overrides and pin-change sources of the port B/C mux.
   Bound into the mux; sees only its ports. */
module pmux_assertions
  import pin_mux_pkg::*;
(
  // Clock and inputs
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire pin_mux_pkg::port_bits_t [3:0] i_port_b,
  input wire logic [3:0] i_pinchg_src_b,
  input wire logic i_analog8_din_disable,
  input wire pin_mux_pkg::periph_req_t i_req,
  input wire logic [3:0] i_pin_b,
  // Pad outputs and pin-change sources
  input wire logic [3:0] o_pad_b_out,
  input wire logic [3:0] o_pad_b_oe_n,
  input wire logic [3:0] o_pad_b_pull_up,
  input wire logic [3:0] o_pad_b_din_en,
  input wire logic [2:0] o_pad_c_out,
  input wire logic [2:0] o_pad_c_oe_n,
  input wire logic [3:0] o_pinchg_src_group1
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  wire periph_req_t r = i_req;
  wire logic tw = r.serial_if_three_wire_mode & ~r.uart1_tx_owns_pin;
  wire logic [3:0] pc = i_pinchg_src_b & {4{r.pinchg_group1_en}};
  property p_b2_data; tw && i_port_b[2].dir_bit |-> !o_pad_b_oe_n[2] && o_pad_b_out[2] == r.three_wire_data_out;
  endproperty
  a_b2_data: assert property (p_b2_data) else $error("B2 serial data wrong");
  property p_b2_pull; tw |-> o_pad_b_pull_up[2] == (i_port_b[2] == 2'b10); endproperty
  a_b2_pull: assert property (p_b2_pull) else $error("B2 pull-up wrong");
  property p_b3_cmp; r.t1_cmp_a_en |-> o_pad_b_oe_n[3] == !i_port_b[3].dir_bit &&
    (o_pad_b_oe_n[3] || o_pad_b_out[3] == r.t1_cmp_a_out); endproperty
  a_b3_cmp: assert property (p_b3_cmp) else $error("B3 compare output wrong");
  property p_clk_out; @(negedge i_core_clk) disable iff (1'b0)
    r.clock_out_fuse |-> !o_pad_c_oe_n[2] && o_pad_c_out[2]; endproperty
  a_clk_out: assert property (p_clk_out) else $error("C2 clock missing");
  property p_b1_din; pc[1] || r.serial_if_start_irq_en |-> o_pad_b_din_en[1]; endproperty
  a_b1_din: assert property (p_b1_din) else $error("B1 input buffer off");
  property p_b3_din; pc[3] || i_analog8_din_disable |-> o_pad_b_din_en[3] == pc[3]; endproperty
  a_b3_din: assert property (p_b3_din) else $error("B3 input buffer wrong");
  property p_b1_rx; r.uart1_rx_active |-> o_pad_b_oe_n[1]; endproperty
  a_b1_rx: assert property (p_b1_rx) else $error("B1 driven while receiving");
  property p_group1; i_ce ##1 i_ce |-> ##1 o_pinchg_src_group1 == ($past(i_pin_b, 2) & {4{r.pinchg_group1_en}});
  endproperty
  a_group1: assert property (p_group1) else $error("pin-change sources wrong");
  c_serial: cover property (tw && i_port_b[2].dir_bit);
  c_cmp: cover property (r.t1_cmp_a_en && i_port_b[3].dir_bit);
  c_analog: cover property (i_analog8_din_disable && !pc[3]);
endmodule

// >>> port_b_c_alt_function_mux.sv
/*
  Alternate-function override logic for port B bits 0-3 and port C bits 0-2.
  Combines port registers with peripheral overrides into pull-up, drive,
  value and input-buffer controls; synchronises pin levels for peripherals.
  Assumes peripherals and port registers run on i_core_clk; pins are async.
*/
module port_b_c_alt_function_mux
  import pin_mux_pkg::*;
(
  // Clock, reset and enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Port registers
  input wire pin_mux_pkg::port_bits_t [3:0] i_port_b,
  input wire pin_mux_pkg::port_bits_t [2:0] i_port_c,
  // Pin-change and analog enables
  input wire logic [3:0] i_pinchg_src_b,
  input wire logic i_analog5_din_disable,
  input wire logic i_analog6_din_disable,
  input wire logic i_analog7_din_disable,
  input wire logic i_analog8_din_disable,
  // Peripheral requests
  input wire pin_mux_pkg::periph_req_t i_req,
  // Pin levels from the pads
  input wire logic [3:0] i_pin_b,
  input wire logic [2:0] i_pin_c,
  // Pad controls
  output logic [3:0] o_pad_b_out,
  output logic [3:0] o_pad_b_oe_n,
  output logic [3:0] o_pad_b_pull_up,
  output logic [3:0] o_pad_b_din_en,
  output logic [2:0] o_pad_c_out,
  output logic [2:0] o_pad_c_oe_n,
  output logic [2:0] o_pad_c_pull_up,
  output logic [2:0] o_pad_c_din_en,
  // Synchronised inputs for peripherals
  output logic [3:0] o_pinchg_src_group1,
  output logic o_three_wire_data_in,
  output logic o_two_wire_data_in,
  output logic o_uart1_rx_in,
  output logic o_usart0_xfer_clk,
  output logic o_t1_capture_in,
  output logic o_three_wire_clock,
  output logic o_ext_irq0_in
);
  import pin_mux_pkg::*;

  // ---------------------------------------------------------------
  // Resolve one pin from its register bits and overrides
  // ---------------------------------------------------------------
  function automatic pin_ctrl_t resolve(input port_bits_t r, input override_t o);
    pin_ctrl_t c;
    logic dir;
    c = '0;
    dir = o.dd_oe ? o.dd_ov : r.dir_bit;
    c.drive = dir;
    c.value = o.pv_oe ? o.pv_ov : r.out_bit;
    c.pull_up = o.pu_oe ? o.pu_ov : (~dir & r.out_bit);
    c.din_en = o.die_oe ? o.die_ov : 1'b1;
    return c;
  endfunction

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The synchroniser word packs port B below port C.
  localparam int N_SYNC = N_PB + N_PC;

  // The pin group widths of the ports are fixed by the package.
  if ($bits(i_pin_b) != N_PB || $bits(i_pin_c) != N_PC)
  begin : g_bad_pin_width
    $error("pin group widths differ from the package");
  end
  if ($bits(i_port_b) != $bits(port_bits_t) * N_PB || $bits(i_port_c) != $bits(port_bits_t) * N_PC)
  begin : g_bad_port_width
    $error("port register widths differ from the package");
  end

  // ---------------------------------------------------------------
  // State: two-stage synchroniser on all pin inputs
  // ---------------------------------------------------------------
  // The first stage may go metastable, so only the second is read.
  typedef struct packed {
    logic [N_SYNC-1:0] sync1;
    logic [N_SYNC-1:0] sync2;
  } state_t;

  state_t st;
  state_t next_st;
  override_t ov_b [N_PB];
  override_t ov_c [N_PC];
  pin_ctrl_t ctl_b [N_PB];
  pin_ctrl_t ctl_c [N_PC];
  logic [3:0] pcg;

  always_comb
  begin
    next_st = st;
    next_st.sync1 = {i_pin_c, i_pin_b};
    next_st.sync2 = st.sync1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      st.sync1 <= {N_SYNC{RST_SYNC}};
      st.sync2 <= {N_SYNC{RST_SYNC}};
    end
    else if (i_ce)
    begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Override tables
  // ---------------------------------------------------------------
  // Pin-change sources of group 1 that also hold the input buffer on.
  always_comb
  begin
    for (int k = 0; k < N_PB; k++)
    begin
      pcg[k] = i_pinchg_src_b[k] & i_req.pinchg_group1_en;
    end
  end

  always_comb
  begin
    // ---------------------------------------------------------------
    // Port B bit 0: UART0 transmitter
    // ---------------------------------------------------------------
    ov_b[PB0] = '0;
    ov_b[PB0].pu_oe = i_req.uart0_tx_owns_pin;
    ov_b[PB0].dd_oe = i_req.uart0_tx_owns_pin;
    ov_b[PB0].dd_ov = 1'b1;
    ov_b[PB0].pv_oe = i_req.uart0_tx_owns_pin;
    ov_b[PB0].pv_ov = i_req.uart0_tx_value;
    ov_b[PB0].die_oe = pcg[PB0] | i_analog5_din_disable;
    ov_b[PB0].die_ov = pcg[PB0];

    // ---------------------------------------------------------------
    // Port B bit 1: UART1 receiver, three-wire in, two-wire data
    // ---------------------------------------------------------------
    // The data line is released while its synchronised level is high and out_bit is clear.
    // Three-wire input adds no override term here.
    ov_b[PB1] = '0;
    ov_b[PB1].pu_oe = i_req.uart1_rx_owns_pin;
    ov_b[PB1].pu_ov = i_req.uart1_rx_pullup;
    ov_b[PB1].dd_oe = i_req.uart1_rx_active | i_req.serial_if_two_wire_mode;
    ov_b[PB1].dd_ov = ~i_req.uart1_rx_active
      & (~st.sync2[PB1] | i_port_b[PB1].out_bit) & i_port_b[PB1].dir_bit;
    ov_b[PB1].pv_oe = ~i_req.uart1_rx_active & i_req.serial_if_two_wire_mode
      & i_port_b[PB1].dir_bit;
    ov_b[PB1].pv_ov = 1'b0;
    ov_b[PB1].die_oe = i_req.serial_if_start_irq_en | pcg[PB1] | i_analog6_din_disable;
    ov_b[PB1].die_ov = i_req.serial_if_start_irq_en | pcg[PB1];

    // ---------------------------------------------------------------
    // Port B bit 2: UART1 transmitter or three-wire data out
    // ---------------------------------------------------------------
    ov_b[PB2] = '0;
    ov_b[PB2].pu_oe = i_req.uart1_tx_owns_pin;
    ov_b[PB2].dd_oe = i_req.uart1_tx_owns_pin;
    ov_b[PB2].dd_ov = 1'b1;
    ov_b[PB2].pv_oe = i_req.uart1_tx_owns_pin | i_req.serial_if_three_wire_mode;
    ov_b[PB2].pv_ov = i_req.uart1_tx_owns_pin ? i_req.uart_tx_pin_value
      : i_req.three_wire_data_out;
    ov_b[PB2].die_oe = pcg[PB2] | i_analog7_din_disable;
    ov_b[PB2].die_ov = pcg[PB2] | i_req.ext_irq0;

    // ---------------------------------------------------------------
    // Port B bit 3: timer 1 compare A
    // ---------------------------------------------------------------
    // Direction stays with software, so the compare value needs it set.
    ov_b[PB3] = '0;
    ov_b[PB3].pv_oe = i_req.t1_cmp_a_en;
    ov_b[PB3].pv_ov = i_req.t1_cmp_a_out;
    ov_b[PB3].die_oe = pcg[PB3] | i_analog8_din_disable;
    ov_b[PB3].die_ov = pcg[PB3];

  end

  always_comb
  begin
    // ---------------------------------------------------------------
    // Port C bit 0: timer 0 compare A
    // ---------------------------------------------------------------
    // Direction stays with software, so the compare value needs it set.
    ov_c[PC0] = '0;
    ov_c[PC0].pv_oe = i_req.t0_cmp_a_en;
    ov_c[PC0].pv_ov = i_req.t0_cmp_a_out;

    // ---------------------------------------------------------------
    // Port C bit 1: serial clock pin in two-wire mode
    // ---------------------------------------------------------------
    // Driving only while out_bit is set lets software stretch the clock.
    ov_c[PC1] = '0;
    ov_c[PC1].pu_oe = i_req.serial_if_two_wire_mode;
    ov_c[PC1].dd_oe = i_req.serial_if_two_wire_mode;
    ov_c[PC1].dd_ov = i_port_c[PC1].out_bit & i_port_c[PC1].dir_bit;
    ov_c[PC1].pv_oe = i_req.serial_if_two_wire_mode & i_port_c[PC1].dir_bit;
    ov_c[PC1].pv_ov = 1'b0;

    // ---------------------------------------------------------------
    // Port C bit 2: system clock output
    // ---------------------------------------------------------------
    ov_c[PC2] = '0;
    ov_c[PC2].pu_oe = i_req.clock_out_fuse;
    ov_c[PC2].dd_oe = i_req.clock_out_fuse;
    ov_c[PC2].dd_ov = 1'b1;
    ov_c[PC2].pv_oe = i_req.clock_out_fuse;
    ov_c[PC2].pv_ov = i_core_clk;
  end

  // ---------------------------------------------------------------
  // Reset state of a pad
  // ---------------------------------------------------------------
  // Pads float with pull-ups off while reset is held, except C2 while clock_out_fuse is set.
  function automatic pin_ctrl_t released(input pin_ctrl_t c);
    pin_ctrl_t r;
    r = c;
    r.drive = 1'b0;
    r.pull_up = 1'b0;
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Port B pad controls
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int k = 0; k < N_PB; k++)
    begin
      ctl_b[k] = resolve(i_port_b[k], ov_b[k]);
      if (i_rst)
      begin
        ctl_b[k] = released(ctl_b[k]);
      end
      o_pad_b_out[k] = ctl_b[k].value;
      o_pad_b_oe_n[k] = ~ctl_b[k].drive;
      o_pad_b_pull_up[k] = ctl_b[k].pull_up;
      o_pad_b_din_en[k] = ctl_b[k].din_en;
    end
  end

  // ---------------------------------------------------------------
  // Port C pad controls
  // ---------------------------------------------------------------
  // The clock pin keeps its override through reset; the others float.
  always_comb
  begin
    for (int k = 0; k < N_PC; k++)
    begin
      ctl_c[k] = resolve(i_port_c[k], ov_c[k]);
      if (i_rst && (k != PC2 || !i_req.clock_out_fuse))
      begin
        ctl_c[k] = released(ctl_c[k]);
      end
      o_pad_c_out[k] = ctl_c[k].value;
      o_pad_c_oe_n[k] = ~ctl_c[k].drive;
      o_pad_c_pull_up[k] = ctl_c[k].pull_up;
      o_pad_c_din_en[k] = ctl_c[k].din_en;
    end
  end

  // ---------------------------------------------------------------
  // Synchronised inputs to peripherals
  // ---------------------------------------------------------------
  // A synchronised pin level passed on only while its function is on.
  function automatic logic gated(input logic en, input logic [N_SYNC-1:0] s, input int idx);
    return en & s[idx];
  endfunction

  // Port B pins.
  always_comb
  begin
    o_pinchg_src_group1 = st.sync2[N_PB-1:0] & {N_PB{i_req.pinchg_group1_en}};
    o_three_wire_data_in = gated(i_req.serial_if_three_wire_mode, st.sync2, PB1);
    o_two_wire_data_in = st.sync2[PB1];
    o_uart1_rx_in = st.sync2[PB1];
  end

  // Port C pins.
  always_comb
  begin
    o_usart0_xfer_clk = gated(i_req.usart0_sync_mode, st.sync2, N_PB + PC0);
    o_t1_capture_in = st.sync2[N_PB + PC1];
    o_three_wire_clock = gated(i_req.serial_if_three_wire_mode | i_req.serial_if_two_wire_mode,
      st.sync2, N_PB + PC1);
    o_ext_irq0_in = st.sync2[N_PB + PC2];
  end

endmodule

// >>> tb.sv
/* Bench for the port B/C mux: drives port bits and requests, checks the pads.
   Assumes pad_model and pmux_assertions are compiled with it. */
`define CHK(a, b) \
  begin \
    checks_done++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("ERROR at %0t: got %h, expected %h", $time, (a), (b)); \
    end \
  end
module tb
  import pin_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  port_bits_t [3:0] pb = '0;
  port_bits_t [2:0] pc = '0;
  periph_req_t rq = '0;
  logic [3:0] src = '0;
  logic [3:0] ad = '0;
  logic [6:0] xv = '0;
  logic [6:0] pin;
  logic [3:0] bo, boe, bpu, bdi, grp;
  logic [2:0] co, coe, cpu;
  logic twd, xck, cap, twc;
  logic twi, urx, ei0;
  logic [2:0] cdi;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  port_b_c_alt_function_mux dut_u (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_port_b(pb), .i_port_c(pc),
    .i_pinchg_src_b(src), .i_analog5_din_disable(ad[0]), .i_analog6_din_disable(ad[1]),
    .i_analog7_din_disable(ad[2]), .i_analog8_din_disable(ad[3]), .i_req(rq), .i_pin_b(pin[3:0]),
    .i_pin_c(pin[6:4]), .o_pad_b_out(bo), .o_pad_b_oe_n(boe), .o_pad_b_pull_up(bpu), .o_pad_b_din_en(bdi),
    .o_pad_c_out(co), .o_pad_c_oe_n(coe), .o_pad_c_pull_up(cpu), .o_pad_c_din_en(cdi), .o_pinchg_src_group1(grp),
    .o_three_wire_data_in(twd), .o_two_wire_data_in(twi), .o_uart1_rx_in(urx), .o_usart0_xfer_clk(xck),
    .o_t1_capture_in(cap), .o_three_wire_clock(twc), .o_ext_irq0_in(ei0));
  pad_model #(.N(7)) pad_u (.i_core_clk(clk), .i_out({co, bo}), .i_oe_n({coe, boe}), .i_pull_up({cpu, bpu}),
    .i_ext_en(7'h7f), .i_ext(xv), .o_pin(pin));
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 400)
    begin
      fails++;
      give_verdict();
    end
  end
  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // Samples C2 in the high and then the low half of the clock.
  task automatic clk_chk();
    #3;
    `CHK({coe[2], co[2]}, 2'b01)
    #20;
    `CHK(co[2], 1'b0)
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    rq.clock_out_fuse = 1'b1;
    go(1);
    `CHK({coe[1:0], boe}, 6'h3f)
    clk_chk();
    go(11);
    rst = 1'b0;
    go(1);
    clk_chk();
    done("clock");
    go(1);
    rq.serial_if_three_wire_mode = 1'b1;
    rq.three_wire_data_out = 1'b1;
    pb[2] = 2'b11;
    xv = 7'h22;
    go(3);
    `CHK({boe[2], bo[2]}, 2'b01)
    `CHK({boe[1], twd}, 2'b11)
    `CHK({cap, twc}, 2'b11)
    `CHK({twi, urx}, 2'b11)
    rq.uart1_tx_owns_pin = 1'b1;
    go(1);
    `CHK(bo[2], 1'b0)
    rq.uart1_tx_owns_pin = 1'b0;
    pb[2] = 2'b10;
    go(1);
    `CHK({boe[2], bpu[2]}, 2'b11)
    rq.uart1_rx_active = 1'b1;
    pb[1] = 2'b11;
    go(1);
    `CHK(boe[1], 1'b1)
    rq.uart1_rx_active = 1'b0;
    rq.serial_if_two_wire_mode = 1'b1;
    go(1);
    `CHK({boe[1], bo[1]}, 2'b00)
    done("serial");
    rq = '{clock_out_fuse: 1'b1, t1_cmp_a_en: 1'b1, t1_cmp_a_out: 1'b1, t0_cmp_a_en: 1'b1,
      t0_cmp_a_out: 1'b1, default: 1'b0};
    pb = '0;
    for (int d = 0; d < 2; d++)
    begin
      pb[3].dir_bit = d[0];
      pc[0].dir_bit = d[0];
      go(1);
      `CHK({boe[3], coe[0]}, {2{~d[0]}})
    end
    `CHK({bo[3], co[0]}, 2'b11)
    done("compare");
    pb = '0;
    pc = '0;
    rq = '{clock_out_fuse: 1'b1, pinchg_group1_en: 1'b1, default: 1'b0};
    src = 4'hf;
    xv = 7'h0a;
    go(3);
    `CHK(bdi, 4'hf)
    `CHK(grp, 4'ha)
    rq.pinchg_group1_en = 1'b0;
    rq.ext_irq0 = 1'b1;
    rq.serial_if_start_irq_en = 1'b1;
    ad = 4'hd;
    go(1);
    `CHK(bdi, 4'h6)
    `CHK(grp, 4'h0)
    done("input");
    rq.clock_out_fuse = 1'b0;
    xv = 7'h50;
    go(3);
    `CHK(xck, 1'b0)
    `CHK({ei0, cpu, cdi}, 7'h47)
    rq.usart0_sync_mode = 1'b1;
    go(1);
    `CHK(xck, 1'b1)
    ce = 1'b0;
    xv = 7'h40;
    go(3);
    `CHK(xck, 1'b1)
    ce = 1'b1;
    go(2);
    `CHK(xck, 1'b0)
    done("xfer_clock");
    give_verdict();
  end
endmodule
bind port_b_c_alt_function_mux pmux_assertions chk_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_port_b(i_port_b), .i_pinchg_src_b(i_pinchg_src_b), .i_req(i_req), .i_pin_b(i_pin_b),
  .i_analog8_din_disable(i_analog8_din_disable), .o_pad_b_out(o_pad_b_out), .o_pad_b_oe_n(o_pad_b_oe_n),
  .o_pad_b_pull_up(o_pad_b_pull_up), .o_pad_b_din_en(o_pad_b_din_en), .o_pad_c_out(o_pad_c_out),
  .o_pad_c_oe_n(o_pad_c_oe_n), .o_pinchg_src_group1(o_pinchg_src_group1));
